// >>> adc_core_model.sv
// Purpose: Analog core stand-in returning a chosen sample
// Assumes: Sample is taken in the strobe cycle or the one after
// Notes:   Shows the inverse elsewhere so a mistimed capture shows up
`timescale 1ns/10ps
module adc_core_model
(
  input  wire        pclk,
  input  wire        sample_strobe,
  input  wire [11:0] sample,
  output wire [11:0] conv_data
);
  reg strobe_d_reg;
  initial strobe_d_reg = 1'b0;
  always @(posedge pclk)
    strobe_d_reg <= sample_strobe;
  assign conv_data = (sample_strobe | strobe_d_reg) ? sample : ~sample;
endmodule // adc_core_model

// >>> adc_ctl_sva.sv
// Purpose: Port-level checks of the converter register control block
// Assumes: One clock domain, pready one cycle after setup
// Notes:   Result alignment is not visible here, the bench judges it
`timescale 1ns/10ps
module adc_ctl_chk
(
  input wire        pclk,
  input wire        presetn,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        converter_power,
  input wire        ext_path_enable,
  input wire [7:0]  analog_inputs,
  input wire [2:0]  internal_source,
  input wire        sample_strobe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("read data upper bits set");
  property p_ctl3; pready && !pwrite && paddr == 8'h08 |-> !prdata[3]; endproperty
  a_ctl3: assert property (p_ctl3) else $error("control bit 3 reads one");
  property p_src43; pready && !pwrite && paddr == 8'h0C |-> prdata[4:3] == 2'b00; endproperty
  a_src43: assert property (p_src43) else $error("source bits 4:3 read one");
  property p_int_off;
    internal_source != 3'h0 |-> analog_inputs == 8'h00 && !ext_path_enable;
  endproperty
  a_int_off: assert property (p_int_off) else $error("pin routed with internal source");
  property p_one_pin; $onehot0(analog_inputs); endproperty
  a_one_pin: assert property (p_one_pin) else $error("more than one analog pin");
  property p_power; !converter_power |-> !ext_path_enable; endproperty
  a_power: assert property (p_power) else $error("path enabled while powered down");
  property p_pulse; sample_strobe |=> !sample_strobe; endproperty
  a_pulse: assert property (p_pulse) else $error("sample strobe longer than a cycle");
  property p_ext_src; ext_path_enable |-> internal_source == 3'h0; endproperty
  a_ext_src: assert property (p_ext_src) else $error("external path with internal code");
  property p_done_pwr; sample_strobe |-> converter_power; endproperty
  a_done_pwr: assert property (p_done_pwr) else $error("completion while disabled");
endmodule // adc_ctl_chk
bind adc_register_control adc_ctl_chk chk_u (.pclk(pclk), .presetn(presetn), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .converter_power(converter_power),
  .ext_path_enable(ext_path_enable), .analog_inputs(analog_inputs),
  .internal_source(internal_source), .sample_strobe(sample_strobe));

// >>> adc_map.vh
// Purpose: Register map and constants for the converter register control block
// Assumes: APB byte addresses, one register per aligned 32-bit word
// Notes:   Offsets and status layout are local choices
`ifndef ADC_MAP_VH
`define ADC_MAP_VH

`define ADDR_RESULT_LOW      4'h0
`define ADDR_RESULT_HIGH     4'h4
`define ADDR_CONTROL         4'h8
`define ADDR_SOURCE_CLOCK    4'hC

`define ADDR_IRQ_STATUS      5'h10
`define ADDR_IRQ_MASK        5'h14

`define CTL_START_BIT        7
`define CTL_BUSY_BIT         6
`define CTL_ENABLE_BIT       5
`define CTL_ALIGN_BIT        4

`define CTL_RESET            8'h00
`define SRC_RESET            8'h00
`define CTL_WRITE_MASK       8'hB7
`define SRC_WRITE_MASK       8'hE7

`define CONV_CYCLES_DEFAULT  14

`endif

// >>> adc_register_control.v
// Purpose: Register control of a 12-bit converter behind an APB slave
// Assumes: Analog core returns sample on conv_data when sampled at completion
// Notes:   Pin routing outputs are registered, one cycle behind the fields
`timescale 1ns/10ps
`include "adc_map.vh"
module adc_register_control
#(
  parameter CHANNELS    = 8,
  parameter CONV_CYCLES = `CONV_CYCLES_DEFAULT
)
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [11:0] conv_data,
  output reg         converter_power,
  output reg         ext_path_enable,
  output reg  [7:0]  analog_inputs,
  output reg  [2:0]  internal_source,
  output reg         sample_strobe,
  output reg         irq
);

  localparam ST_IDLE = 2'b00;
  localparam ST_CONV = 2'b01;
  localparam ST_DONE = 2'b10;

  reg  [7:0]  converter_control_reg;
  reg  [7:0]  source_and_clock_select_reg;
  reg  [7:0]  result_high_byte_reg;
  reg  [7:0]  result_low_byte_reg;
  reg         conversion_busy_reg;
  reg         start_seen_reg;
  reg  [1:0]  state_reg;
  reg  [7:0]  cycle_reg;
  reg         irq_status_reg;
  reg         irq_mask_reg;
  reg  [31:0] rdata_next;
  wire        conv_tick;
  wire        wr_access;
  wire        rd_access;
  wire        start_fire;
  wire        done_event;
  wire        converter_enable;
  wire        result_alignment;
  wire [2:0]  channel_select;
  wire [2:0]  input_source_select;
  wire [2:0]  conversion_clock_select;

  assign wr_access = psel & penable & pwrite & pready;
  assign rd_access = psel & penable & ~pwrite & pready;
  assign converter_enable        = converter_control_reg[`CTL_ENABLE_BIT];
  assign result_alignment        = converter_control_reg[`CTL_ALIGN_BIT];
  assign channel_select          = converter_control_reg[2:0];
  assign input_source_select     = source_and_clock_select_reg[7:5];
  assign conversion_clock_select = source_and_clock_select_reg[2:0];

  // Source decode, used for path enable and internal selection
  function is_external;
    input [2:0] src;
    begin
      is_external = (src[1:0] == 2'b00);
    end
  endfunction

  // Channel decode; four-channel part leaves undefined codes unrouted
  function [7:0] channel_onehot;
    input [2:0] code;
    input       four_only;
    begin
      channel_onehot = 8'h01 << code;
      if (four_only && (code == 3'h1 || code == 3'h3 || code == 3'h4 || code == 3'h5))
        channel_onehot = 8'h00;
    end
  endfunction

  // Start bit falling while set earlier forms the start pulse
  // Full address match, so an alias of the low nibble never starts a conversion
  assign start_fire = wr_access && (paddr == {4'h0, `ADDR_CONTROL}) && start_seen_reg
                      && !pwdata[`CTL_START_BIT];
  assign done_event = (state_reg == ST_DONE);

  conv_clock_divider u_div
  (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (state_reg == ST_CONV),
    .code    (conversion_clock_select),
    .tick    (conv_tick)
  );

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      converter_control_reg       <= `CTL_RESET;
      source_and_clock_select_reg <= `SRC_RESET;
      start_seen_reg              <= 1'b0;
      irq_mask_reg                <= 1'b0;
    end
    else if (wr_access)
    begin
      if (paddr == {4'h0, `ADDR_CONTROL})
      begin
        // busy and bit 3 not writable
        converter_control_reg <= pwdata[7:0] & `CTL_WRITE_MASK;
        start_seen_reg <= pwdata[`CTL_START_BIT] & ~converter_control_reg[`CTL_START_BIT]
                          | (start_seen_reg & pwdata[`CTL_START_BIT]);
      end
      if (paddr == {4'h0, `ADDR_SOURCE_CLOCK})
        // bits 4 and 3 stay zero
        source_and_clock_select_reg <= pwdata[7:0] & `SRC_WRITE_MASK;
      if (paddr == {3'h0, `ADDR_IRQ_MASK})
        irq_mask_reg <= pwdata[0];
    end
  end

  // Conversion sequencer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg            <= ST_IDLE;
      cycle_reg            <= 8'h00;
      conversion_busy_reg  <= 1'b0;
      result_high_byte_reg <= 8'h00;
      result_low_byte_reg  <= 8'h00;
      sample_strobe        <= 1'b0;
    end
    else
    begin
      sample_strobe <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          // start needs enable and an idle converter
          if (start_fire && converter_enable)
          begin
            conversion_busy_reg <= 1'b1;
            cycle_reg           <= 8'h00;
            state_reg           <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          if (!converter_enable)
          begin
            conversion_busy_reg <= 1'b0;
            state_reg           <= ST_IDLE;
          end
          else if (conv_tick)
          begin
            if (cycle_reg == CONV_CYCLES - 1)
            begin
              sample_strobe <= 1'b1;
              state_reg     <= ST_DONE;
            end
            cycle_reg <= cycle_reg + 8'h01;
          end
        end
        ST_DONE:
        begin
          if (converter_enable)
          begin
            if (result_alignment)
            begin
              result_high_byte_reg <= {4'h0, conv_data[11:8]};
              result_low_byte_reg  <= conv_data[7:0];
            end
            else
            begin
              result_high_byte_reg <= conv_data[11:4];
              result_low_byte_reg  <= {conv_data[3:0], 4'h0};
            end
          end
          conversion_busy_reg <= 1'b0;
          state_reg           <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Status is sticky; a read clears it but a same-cycle completion wins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status_reg <= 1'b0;
    else if (done_event)
      irq_status_reg <= 1'b1;
    else if (rd_access && paddr == {3'h0, `ADDR_IRQ_STATUS})
      irq_status_reg <= 1'b0;
  end

  // Analog side control and routing
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      converter_power <= 1'b0;
      ext_path_enable <= 1'b0;
      analog_inputs   <= 8'h00;
      internal_source <= 3'h0;
      irq             <= 1'b0;
    end
    else
    begin
      converter_power <= converter_enable;
      // external path only for 000 and 100
      ext_path_enable <= converter_enable & is_external(input_source_select);
      // selected pin set analog, digital and pull-up off
      analog_inputs   <= is_external(input_source_select) ?
                         channel_onehot(channel_select, CHANNELS == 4) : 8'h00;
      // internal source code, zero when external
      internal_source <= is_external(input_source_select) ? 3'h0 : input_source_select;
      irq             <= (irq_status_reg | done_event) & irq_mask_reg;
    end
  end

  // APB read mux
  always @*
  begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      {4'h0, `ADDR_RESULT_LOW}:   rdata_next = {24'h000000, result_low_byte_reg};
      {4'h0, `ADDR_RESULT_HIGH}:  rdata_next = {24'h000000, result_high_byte_reg};
      {4'h0, `ADDR_CONTROL}:      rdata_next = {24'h000000, converter_control_reg[7],
                                                conversion_busy_reg,
                                                converter_control_reg[5:0]};
      {4'h0, `ADDR_SOURCE_CLOCK}: rdata_next = {24'h000000, source_and_clock_select_reg};
      {3'h0, `ADDR_IRQ_STATUS}:   rdata_next = {31'h00000000, irq_status_reg};
      {3'h0, `ADDR_IRQ_MASK}:     rdata_next = {31'h00000000, irq_mask_reg};
      default:                    rdata_next = 32'h0000_0000;
    endcase
  end

  // No wait state: pready rises in the first access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pready  <= 1'b1;
      prdata  <= rdata_next;
      pslverr <= (paddr > {3'h0, `ADDR_IRQ_MASK}) || (paddr[1:0] != 2'b00);
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // adc_register_control

// >>> adc_register_control_tb.sv
// Purpose: Self-checking bench of the converter register control block
// Assumes: Short conversion count of 2 clocks for run time
// Notes:   APB master waits on pready under a bound
`timescale 1ns/10ps
`include "adc_map.vh"
module adc_register_control_tb;
  reg         pclk, presetn, psel, penable, pwrite, err;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  reg  [11:0] sample;
  wire [31:0] prdata;
  wire        pready, pslverr, converter_power, ext_path_enable, sample_strobe, irq;
  wire [11:0] conv_data;
  wire [7:0]  analog_inputs;
  wire [7:0]  analog_inputs_4ch;
  integer     n_strobe = 0;
  wire [2:0]  internal_source;
  integer     n_fail, cmp_count, i;
  adc_register_control #(.CHANNELS(8), .CONV_CYCLES(2)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_data(conv_data),
    .converter_power(converter_power), .ext_path_enable(ext_path_enable),
    .analog_inputs(analog_inputs), .internal_source(internal_source),
    .sample_strobe(sample_strobe), .irq(irq));
  // Four-channel variant on the same bus, only its pin routing is judged
  adc_register_control #(.CHANNELS(4), .CONV_CYCLES(2)) dut4_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .conv_data(conv_data),
    .converter_power(), .ext_path_enable(), .analog_inputs(analog_inputs_4ch),
    .internal_source(), .sample_strobe(), .irq());
  adc_core_model core_u (.pclk(pclk), .sample_strobe(sample_strobe), .sample(sample),
    .conv_data(conv_data));
  // Completed conversions, an extra or missing one shows in the final count
  always @(posedge pclk)
    if (sample_strobe === 1'b1)
      n_strobe <= n_strobe + 1;
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task print_verdict;
    begin
      $display("Compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        n_fail = n_fail + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // No wait state is expected, the bound only guards a hang
  task apb(input w, input [7:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20)
      begin
        @(posedge pclk);
        k = k + 1;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 20)
      begin
        n_fail = n_fail + 1;
        print_verdict;
      end
    end
  endtask
  task rdchk(input [7:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
    end
  endtask
  task wait_idle;
    integer j;
    begin
      j = 0;
      rd = 32'h40;
      while (rd[6] && j < 300)
      begin
        apb(1'b0, `ADDR_CONTROL, 32'h0);
        j = j + 1;
      end
      if (j == 300)
      begin
        n_fail = n_fail + 1;
        print_verdict;
      end
    end
  endtask
  task t_convert(input al, input [2:0] code, input [11:0] d, input msk, input [15:0] hl);
    begin
      sample = d;
      apb(1'b1, `ADDR_IRQ_MASK, {31'h0, msk});
      apb(1'b1, `ADDR_SOURCE_CLOCK, {29'h0, code});
      apb(1'b1, `ADDR_CONTROL, {27'h5, al, 4'h0});
      apb(1'b1, `ADDR_CONTROL, {27'h1, al, 4'h0});
      rdchk(`ADDR_CONTROL, {27'h3, al, 4'h0}); // busy
      apb(1'b1, `ADDR_CONTROL, {27'h5, al, 4'h0});
      apb(1'b1, `ADDR_CONTROL, {27'h1, al, 4'h0});
      // Divide by 128 with two clocks lasts 256 cycles
      if (code == 3'h7)
        repeat (100) @(posedge pclk);
      rdchk(`ADDR_CONTROL, {27'h3, al, 4'h0}); // still busy
      wait_idle;
      repeat (2) @(posedge pclk);
      chk(irq, msk); // request level
      rdchk(`ADDR_IRQ_STATUS, 32'h1); // sticky status
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0); // cleared by read
      rdchk(`ADDR_RESULT_HIGH, hl[15:8]); // high byte
      rdchk(`ADDR_RESULT_LOW, hl[7:0]); // low byte
    end
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, sample} = 0;
    n_fail = 0;
    cmp_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`ADDR_CONTROL, 32'h0); // reset value
    rdchk(`ADDR_SOURCE_CLOCK, 32'h0); // reset value
    rdchk(8'h20, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, `ADDR_SOURCE_CLOCK, 32'hFF);
    rdchk(`ADDR_SOURCE_CLOCK, 32'hE7); // unused bits
    apb(1'b1, `ADDR_CONTROL, 32'h48);
    rdchk(`ADDR_CONTROL, 32'h0); // busy not writable
    apb(1'b1, `ADDR_CONTROL, 32'h80);
    apb(1'b1, `ADDR_CONTROL, 32'h00);
    rdchk(`ADDR_CONTROL, 32'h0); // no start when off
    t_convert(1'b0, 3'h4, 12'hABC, 1'b1, 16'hABC0);
    t_convert(1'b1, 3'h7, 12'h5A3, 1'b0, 16'h05A3);
    sample = 12'h123;
    // Start a slow conversion, then disable it before completion
    apb(1'b1, `ADDR_CONTROL, 32'hB0);
    apb(1'b1, `ADDR_CONTROL, 32'h30);
    apb(1'b1, `ADDR_CONTROL, 32'h10);
    repeat (300) @(posedge pclk);
    rdchk(`ADDR_CONTROL, 32'h10); // aborted, idle
    chk(converter_power, 1'b0); // powered down
    rdchk(`ADDR_RESULT_HIGH, 32'h05); // result kept
    rdchk(`ADDR_RESULT_LOW, 32'hA3); // result kept
    for (i = 0; i < 8; i = i + 1)
    begin
      apb(1'b1, `ADDR_CONTROL, 32'h20 | i);
      apb(1'b1, `ADDR_SOURCE_CLOCK, i << 5);
      repeat (2) @(posedge pclk);
      chk(ext_path_enable, i == 0 || i == 4); // external codes
      chk(internal_source, (i == 0 || i == 4) ? 0 : i); // internal codes
      chk(analog_inputs, (i == 0 || i == 4) ? 8'h01 << i : 8'h00); // path off
      apb(1'b1, `ADDR_SOURCE_CLOCK, 32'h0);
      repeat (2) @(posedge pclk);
      chk(analog_inputs, 8'h01 << i); // channel per code
      chk(analog_inputs_4ch, (i == 0 || i == 2 || i == 6 || i == 7) ? 8'h01 << i : 8'h00);
    end
    chk(n_strobe, 2); // two completed conversions
    print_verdict;
  end
endmodule // adc_register_control_tb

// >>> conv_clock_divider.v
// Purpose: Conversion clock tick generator, system clock divided by 2**code
// Assumes: Runs on pclk, one tick pulse per conversion clock period
// Notes:   Counter restarts whenever run is low so the first tick is aligned
`timescale 1ns/10ps
module conv_clock_divider
(
  input  wire       pclk,
  input  wire       presetn,
  input  wire       run,
  input  wire [2:0] code,
  output reg        tick
);

  reg  [6:0] count_reg;
  wire [6:0] limit;

  // Divide ratio minus one
  assign limit = (7'h01 << code) - 7'h01;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg <= 7'h00;
      tick      <= 1'b0;
    end
    else if (!run)
    begin
      count_reg <= 7'h00;
      tick      <= 1'b0;
    end
    else if (count_reg >= limit)
    begin
      count_reg <= 7'h00;
      tick      <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 7'h01;
      tick      <= 1'b0;
    end
  end

endmodule // conv_clock_divider
